// ---- rtl/hirql_defines.vh ----
`ifndef HIRQL_DEFINES_VH
`define HIRQL_DEFINES_VH

// ----------------------------------------
// Port data register layout
// ----------------------------------------
`define HIRQL_PORT_W 8
`define HIRQL_PORT_RESET 8'h00
`define HIRQL_BIT_CHAN2 3
`define HIRQL_BIT_CHAN1P 4
`define HIRQL_BIT_CHAN1S 5
`define HIRQL_ODR_RESET 8'h00
`define HIRQL_STR_RESET 8'h00

`endif

// ---- rtl/hirql_sync.v ----
`timescale 1ns/1ns
// ----------------------------------------
// Two-stage synchroniser
// ----------------------------------------
module hirql_sync #(
  parameter RESET_VAL = 1'b1
) (
  input wire clk_in,
  input wire rst_in,
  input wire d_in,
  output reg q_out
);
  reg meta_r;

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= RESET_VAL;
      q_out <= RESET_VAL;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule

// ---- rtl/hirql_top.v ----
`timescale 1ns/1ns
`include "hirql_defines.vh"

// Summary of operation
// - Latches only active in slave host mode.
// - Bit 3 set by 1-after-0, cleared by writing 0.
// - Bit 4 set by 1-after-0, cleared likewise.
// - Bit 5 set by 1-after-0, cleared likewise.
// - Register one read clears both channel-one latches.
// - Register two read clears channel-two latch.
// - Host and slave must not collide accesses.
// - Address high reads status, low reads data.
module hirql_top #(
  parameter PORT_W = `HIRQL_PORT_W
) (
  input wire MCLK_IN,
  input wire SYS_RST_IN,
  input wire HOST_IFACE_ENABLE_IN,
  input wire SINGLE_CHIP_MODE_IN,
  input wire PORT_WR_IN,
  input wire PORT_RD_IN,
  input wire [PORT_W-1:0] PORT_WDATA_IN,
  output reg [PORT_W-1:0] PORT_RDATA_OUT,
  output wire [PORT_W-1:0] PORT_FOUR_DATA_REG_OUT,
  input wire [7:0] OUTPUT_DATA_REG_ONE_IN,
  input wire [7:0] OUTPUT_DATA_REG_TWO_IN,
  input wire [7:0] STATUS_REG_ONE_IN,
  input wire [7:0] STATUS_REG_TWO_IN,
  input wire HOST_SELECT_ONE_N_IN,
  input wire HOST_SELECT_TWO_N_IN,
  input wire HOST_ADDR_BIT_IN,
  input wire HOST_READ_STROBE_N_IN,
  output reg [7:0] HOST_RDATA_OUT,
  output wire HOST_RDATA_OE_N_OUT,
  output wire CHAN2_HOST_IRQ_OUT,
  output wire CHAN1_PRIMARY_HOST_IRQ_OUT,
  output wire CHAN1_SECONDARY_HOST_IRQ_OUT
);
  // ----------------------------------------
  // Host pin synchronisers
  // ----------------------------------------
  wire cs1_n_s;
  wire cs2_n_s;
  wire ha0_s;
  wire rd_n_s;
  reg rd_n_d_r;
  reg [PORT_W-1:0] port_four_data_reg_r;
  reg [PORT_W-1:0] port_four_data_reg_nxt;
  reg [PORT_W-1:0] read_zero_r;
  reg [PORT_W-1:0] read_zero_nxt;
  wire slave_mode;
  wire rd_fall;
  wire clr_one;
  wire clr_two;
  wire [PORT_W-1:0] irq_mask;
  wire [PORT_W-1:0] host_clr;
  wire [PORT_W-1:0] wr_zero;
  wire [PORT_W-1:0] wr_set;
  wire [PORT_W-1:0] wr_plain;
  wire [PORT_W-1:0] latch_bits;
  wire sel_one_act;
  wire sel_two_act;
  wire host_rd_act;
  wire [7:0] word_one;
  wire [7:0] word_two;
  integer i;

  // ----------------------------------------
  // Latch bit positions
  // ----------------------------------------
  localparam [PORT_W-1:0] lsb_one = {{(PORT_W-1){1'b0}}, 1'b1};
  localparam [PORT_W-1:0] mask_chan2 = lsb_one << `HIRQL_BIT_CHAN2;
  localparam [PORT_W-1:0] mask_chan1p = lsb_one << `HIRQL_BIT_CHAN1P;
  localparam [PORT_W-1:0] mask_chan1s = lsb_one << `HIRQL_BIT_CHAN1S;
  localparam [PORT_W-1:0] mask_chan1 = mask_chan1p | mask_chan1s;
  localparam [PORT_W-1:0] mask_all = mask_chan2 | mask_chan1;

  // ----------------------------------------
  // Two-flop synchronisers
  // ----------------------------------------
  hirql_sync #(
    .RESET_VAL(1'b1)
  ) u_cs1 (
    .clk_in(MCLK_IN),
    .rst_in(SYS_RST_IN),
    .d_in(HOST_SELECT_ONE_N_IN),
    .q_out(cs1_n_s)
  );
  hirql_sync #(
    .RESET_VAL(1'b1)
  ) u_cs2 (
    .clk_in(MCLK_IN),
    .rst_in(SYS_RST_IN),
    .d_in(HOST_SELECT_TWO_N_IN),
    .q_out(cs2_n_s)
  );
  hirql_sync #(
    .RESET_VAL(1'b0)
  ) u_ha0 (
    .clk_in(MCLK_IN),
    .rst_in(SYS_RST_IN),
    .d_in(HOST_ADDR_BIT_IN),
    .q_out(ha0_s)
  );
  hirql_sync #(
    .RESET_VAL(1'b1)
  ) u_rd (
    .clk_in(MCLK_IN),
    .rst_in(SYS_RST_IN),
    .d_in(HOST_READ_STROBE_N_IN),
    .q_out(rd_n_s)
  );

  always @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      rd_n_d_r <= 1'b1;
    end else begin
      rd_n_d_r <= rd_n_s;
    end
  end

  // ----------------------------------------
  // Host read decode
  // ----------------------------------------
  assign slave_mode = HOST_IFACE_ENABLE_IN & SINGLE_CHIP_MODE_IN;
  assign rd_fall = rd_n_d_r & ~rd_n_s;
  assign sel_one_act = ~cs1_n_s & ~rd_n_s;
  assign sel_two_act = ~cs2_n_s & ~rd_n_s;
  assign clr_one = slave_mode & rd_fall & ~cs1_n_s & ~ha0_s;
  assign clr_two = slave_mode & rd_fall & ~cs2_n_s & ~ha0_s;
  assign irq_mask = slave_mode ? mask_all : {PORT_W{1'b0}};
  assign host_clr = ({PORT_W{clr_two}} & mask_chan2) |
    ({PORT_W{clr_one}} & mask_chan1);

  // ----------------------------------------
  // Slave write classification
  // ----------------------------------------
  assign wr_zero = {PORT_W{PORT_WR_IN}} & irq_mask & ~PORT_WDATA_IN;
  assign wr_set = {PORT_W{PORT_WR_IN}} & irq_mask & PORT_WDATA_IN & read_zero_r;
  assign wr_plain = {PORT_W{PORT_WR_IN}} & ~irq_mask;

  // ----------------------------------------
  // Host data bus
  // ----------------------------------------
  assign word_one = ha0_s ? STATUS_REG_ONE_IN : OUTPUT_DATA_REG_ONE_IN;
  assign word_two = ha0_s ? STATUS_REG_TWO_IN : OUTPUT_DATA_REG_TWO_IN;
  assign host_rd_act = slave_mode & (sel_one_act | sel_two_act);
  assign HOST_RDATA_OE_N_OUT = ~host_rd_act;

  always @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      HOST_RDATA_OUT <= `HIRQL_ODR_RESET;
    end else if (sel_one_act) begin
      HOST_RDATA_OUT <= word_one;
    end else if (sel_two_act) begin
      HOST_RDATA_OUT <= word_two;
    end
  end

  // ----------------------------------------
  // Port data register and latches
  // ----------------------------------------
  always @* begin
    read_zero_nxt = read_zero_r;
    if (PORT_RD_IN) begin
      read_zero_nxt = ~port_four_data_reg_r;
    end
    if (PORT_WR_IN) begin
      read_zero_nxt = read_zero_nxt & ~irq_mask;
    end
  end

  always @* begin
    port_four_data_reg_nxt = port_four_data_reg_r;
    for (i = 0; i < PORT_W; i = i + 1) begin
      if (wr_zero[i]) begin
        port_four_data_reg_nxt[i] = 1'b0;
      end else if (wr_set[i]) begin
        port_four_data_reg_nxt[i] = 1'b1;
      end else if (wr_plain[i]) begin
        port_four_data_reg_nxt[i] = PORT_WDATA_IN[i];
      end else if (host_clr[i]) begin
        port_four_data_reg_nxt[i] = 1'b0;
      end
    end
  end

  always @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      read_zero_r <= {PORT_W{1'b0}};
    end else begin
      read_zero_r <= read_zero_nxt;
    end
  end

  always @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      port_four_data_reg_r <= `HIRQL_PORT_RESET;
    end else begin
      port_four_data_reg_r <= port_four_data_reg_nxt;
    end
  end

  always @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      PORT_RDATA_OUT <= `HIRQL_PORT_RESET;
    end else begin
      PORT_RDATA_OUT <= port_four_data_reg_nxt;
    end
  end

  // ----------------------------------------
  // Host interrupt pins
  // ----------------------------------------
  assign latch_bits = port_four_data_reg_r & irq_mask;
  assign PORT_FOUR_DATA_REG_OUT = port_four_data_reg_r;
  assign CHAN2_HOST_IRQ_OUT = latch_bits[`HIRQL_BIT_CHAN2];
  assign CHAN1_PRIMARY_HOST_IRQ_OUT = latch_bits[`HIRQL_BIT_CHAN1P];
  assign CHAN1_SECONDARY_HOST_IRQ_OUT = latch_bits[`HIRQL_BIT_CHAN1S];
endmodule

// ---- verification/hirql_chk.sv ----
`timescale 1ns/1ns
// ----
// Latch and host pin checks.
// ----
module hirql_chk #(parameter PORT_W = 8) (
  input logic MCLK_IN, SYS_RST_IN, HOST_IFACE_ENABLE_IN, SINGLE_CHIP_MODE_IN,
  input logic PORT_WR_IN, PORT_RD_IN, HOST_SELECT_ONE_N_IN, HOST_SELECT_TWO_N_IN,
  input logic HOST_ADDR_BIT_IN, HOST_READ_STROBE_N_IN, CHAN2_HOST_IRQ_OUT,
  input logic CHAN1_PRIMARY_HOST_IRQ_OUT, CHAN1_SECONDARY_HOST_IRQ_OUT,
  input logic [PORT_W-1:0] PORT_WDATA_IN, PORT_FOUR_DATA_REG_OUT,
  input logic HOST_RDATA_OE_N_OUT,
  input logic [7:0] HOST_RDATA_OUT, STATUS_REG_ONE_IN);
  wire m = HOST_IFACE_ENABLE_IN & SINGLE_CHIP_MODE_IN;
  wire [PORT_W-1:0] p = PORT_FOUR_DATA_REG_OUT;
  wire [2:0] q = {CHAN1_SECONDARY_HOST_IRQ_OUT, CHAN1_PRIMARY_HOST_IRQ_OUT, CHAN2_HOST_IRQ_OUT};
  wire fl = m & !HOST_ADDR_BIT_IN;
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  a_irq_pins_mirror: assert property (q == ({3{m}} & p[5:3]))
    else $error("irq pins");
  a_plain_port_bits: assert property (!m && PORT_WR_IN |=> p == $past(PORT_WDATA_IN))
    else $error("plain data");
  a_zero_clears_three: assert property (m && PORT_WR_IN && !PORT_WDATA_IN[3] |=> !p[3])
    else $error("zero write");
  a_zero_clears_five: assert property (m && PORT_WR_IN && !PORT_WDATA_IN[5] |=> !p[5])
    else $error("zero write");
  a_armed_set:
    assert property (m && PORT_RD_IN && !p[4] ##1 PORT_WR_IN && PORT_WDATA_IN[4] |=> p[4])
    else $error("armed set");
  a_read_one_clears:
    assert property (fl && $fell(HOST_READ_STROBE_N_IN) && !HOST_SELECT_ONE_N_IN
      |-> ##[1:4] (p[5:4] == 0 || PORT_WR_IN)) else $error("clear one");
  a_read_two_clears:
    assert property (fl && $fell(HOST_READ_STROBE_N_IN) && !HOST_SELECT_TWO_N_IN
      |-> ##[1:4] (!p[3] || PORT_WR_IN)) else $error("clear two");
  a_status_read:
    assert property ((!HOST_SELECT_ONE_N_IN && !HOST_READ_STROBE_N_IN && HOST_ADDR_BIT_IN)
      [*5] |-> HOST_RDATA_OUT == STATUS_REG_ONE_IN) else $error("status");
  a_oe_idle_high:
    assert property (HOST_READ_STROBE_N_IN [*3] |-> HOST_RDATA_OE_N_OUT)
    else $error("bus enable idle");
  a_oe_drive_low:
    assert property ((m && !HOST_SELECT_ONE_N_IN && !HOST_READ_STROBE_N_IN) [*3]
      |-> !HOST_RDATA_OE_N_OUT) else $error("bus enable drive");
endmodule
bind hirql_top hirql_chk #(.PORT_W(PORT_W)) u_chk (.*);

// ---- verification/hirql_host_model.sv ----
`timescale 1ns/1ns
// ----
// Host processor that reads the output and status registers.
// ----
module hirql_host_model (
  input logic clk_in,
  input logic [7:0] rdata_in,
  output logic sel1_n_out = 1,
  output logic sel2_n_out = 1,
  output logic addr_out = 1,
  output logic rd_n_out = 1
);
  task read(input logic two, a, output logic [7:0] d);
    @(negedge clk_in);
    sel1_n_out = two;
    sel2_n_out = !two;
    addr_out = a;
    rd_n_out = 0;
    repeat (5) @(negedge clk_in);
    d = rdata_in;
    {sel1_n_out, sel2_n_out, rd_n_out, addr_out} = {3'h7, !a};
    repeat (2) @(negedge clk_in);
  endtask
endmodule

// ---- verification/test_host_interrupt_request_latches.sv ----
`timescale 1ns/1ns
// ----
// Slave port and host read sequences.
// ----
module test_host_interrupt_request_latches;
  logic clk = 0, rst = 1, en = 0, sc = 1, wr = 0, rd = 0, s1n, s2n, ha, rsn;
  logic [7:0] wd = 0, pq, pr, hd, got;
  logic [2:0] irq;
  logic oen;
  int mismatches = 0, checks = 0, cyc = 0;
  hirql_top u_dut (.MCLK_IN(clk), .SYS_RST_IN(rst), .HOST_IFACE_ENABLE_IN(en),
    .SINGLE_CHIP_MODE_IN(sc), .PORT_WR_IN(wr), .PORT_RD_IN(rd), .PORT_WDATA_IN(wd),
    .PORT_RDATA_OUT(pr), .PORT_FOUR_DATA_REG_OUT(pq), .OUTPUT_DATA_REG_ONE_IN(8'h5a),
    .OUTPUT_DATA_REG_TWO_IN(8'h3c), .STATUS_REG_ONE_IN(8'hc3), .STATUS_REG_TWO_IN(8'h96),
    .HOST_SELECT_ONE_N_IN(s1n), .HOST_SELECT_TWO_N_IN(s2n), .HOST_ADDR_BIT_IN(ha),
    .HOST_READ_STROBE_N_IN(rsn), .HOST_RDATA_OUT(hd), .HOST_RDATA_OE_N_OUT(oen),
    .CHAN2_HOST_IRQ_OUT(irq[0]), .CHAN1_PRIMARY_HOST_IRQ_OUT(irq[1]),
    .CHAN1_SECONDARY_HOST_IRQ_OUT(irq[2]));
  hirql_host_model u_host (.clk_in(clk), .rdata_in(hd), .sel1_n_out(s1n),
    .sel2_n_out(s2n), .addr_out(ha), .rd_n_out(rsn));
  initial forever #50 clk = ~clk;
  task ck(input string n, input logic [7:0] e, s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task sl(input logic arm, input logic [7:0] d);
    @(negedge clk) rd = arm;
    @(negedge clk) {rd, wr, wd} = {2'b01, d};
    @(negedge clk) wr = 0;
  endtask
  task summarize;
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      mismatches++;
      summarize;
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    {rst, en} = 2'b01;
    ck("irq", 8'h00, {5'h0, irq});
    sl(0, 8'h38);
    ck("port", 8'h00, pq);
    sl(1, 8'h38);
    ck("irq", 8'h07, {5'h0, irq});
    u_host.read(0, 0, got);
    ck("output_data_reg_one", 8'h5a, got);
    ck("irq", 8'h01, {5'h0, irq});
    u_host.read(1, 0, got);
    ck("output_data_reg_two", 8'h3c, got);
    ck("irq", 8'h00, {5'h0, irq});
    sl(1, 8'h38);
    u_host.read(0, 1, got);
    ck("status", 8'hc3, got);
    u_host.read(1, 1, got);
    ck("status2", 8'h96, got);
    ck("irq", 8'h07, {5'h0, irq});
    ck("oen", 8'h01, {7'h0, oen});
    sl(0, 8'h00);
    ck("port", 8'h00, pq);
    sc = 0;
    sl(0, 8'h38);
    u_host.read(0, 0, got);
    ck("port", 8'h38, pq);
    ck("irq", 8'h00, {5'h0, irq});
    ck("rdata", 8'h38, pr);
    summarize;
  end
endmodule
